// ### core/light_prox_regs.svh
// Register offsets, fields, reset values and timing constants of the light/proximity readout.
// Assumes inclusion by bare name from the package and the core modules.
`ifndef LIGHT_PROX_REGS_SVH
`define LIGHT_PROX_REGS_SVH

`define CMD1_ADDR          8'h00
`define CMD2_ADDR          8'h01
`define RESULT_LO_ADDR     8'h02
`define RESULT_HI_ADDR     8'h03
`define LOW_THR_LO_ADDR    8'h04
`define LOW_THR_HI_ADDR    8'h05
`define HIGH_THR_LO_ADDR   8'h06
`define HIGH_THR_HI_ADDR   8'h07

`define LOW_THR_RESET      8'h00
`define HIGH_THR_RESET     8'hff
`define CMD_RESET          8'h00

`define CMD1_FLAG_BIT      2
`define CMD1_MODE_HI       7
`define CMD1_MODE_LO       5
`define CMD1_PERSIST_HI    1
`define CMD1_PERSIST_LO    0
`define CMD2_SCHEME_BIT    7
`define CMD2_RES_HI        3
`define CMD2_RES_LO        2

`define PERSIST_CNT_1      5'h01
`define PERSIST_CNT_4      5'h04
`define PERSIST_CNT_8      5'h08
`define PERSIST_CNT_16     5'h10

`define RES_CYC_16         17'h10000
`define RES_CYC_12         17'h01000
`define RES_CYC_8          17'h00100
`define RES_CYC_4          17'h00010

// Nominal internal oscillator rate in kHz with the recommended timing resistor
`define OSC_RATE_KHZ       725
`define SYS_RATE_KHZ       100000

`endif

// ### core/light_prox_pkg.sv
// Types shared by the light/proximity readout core.
// Assumes the register header sits beside it.
`include "light_prox_regs.svh"

package light_prox_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       done;
    } reg_req_t;

    typedef struct packed {
        logic [1:0] res_sel;
        logic       scheme;
        logic       run;
    } conv_cfg_t;

    typedef enum logic [1:0] {
        RES_16,
        RES_12,
        RES_8,
        RES_4
    } res_t;
endpackage : light_prox_pkg

// ### core/conv_timer.sv
// Integration timer: counts 2^n ticks of the internal oscillator enable.
// Assumes osc_tick is a one-cycle pulse at the oscillator rate.
`timescale 1ns/10ps
`default_nettype none
`include "light_prox_regs.svh"

module conv_timer (
    input  wire logic                    clk,      // System clock
    input  wire logic                    rst_n,    // Synchronous reset, low
    input  wire logic                    osc_tick, // Oscillator enable pulse
    input  wire light_prox_pkg::conv_cfg_t cfg,    // Resolution and run
    output logic                         done      // Integration finished pulse
);
    import light_prox_pkg::*;

    logic [16:0] cnt_q;

    function automatic logic [16:0] res_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    res_cycles = `RES_CYC_16;
            2'h1:    res_cycles = `RES_CYC_12;
            2'h2:    res_cycles = `RES_CYC_8;
            default: res_cycles = `RES_CYC_4;
        endcase
    endfunction : res_cycles

    always_ff @(posedge clk) begin
        if (!rst_n || !cfg.run) begin
            cnt_q <= 17'h00000;
        end else if (osc_tick) begin
            if (cnt_q + 17'h00001 >= res_cycles(cfg.res_sel)) begin
                cnt_q <= 17'h00000;
            end else begin
                cnt_q <= cnt_q + 17'h00001;
            end
        end
    end

    assign done = cfg.run && osc_tick && (cnt_q + 17'h00001 >= res_cycles(cfg.res_sel));

    res4_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        done && cfg.res_sel == 2'h3 && cfg.run |-> cnt_q == 17'h0000f)
        else $error("integration did not end after 16 ticks");
endmodule : conv_timer
`default_nettype wire

// ### core/light_prox_core.sv
// Register file, conversion sequencing, result scaling and threshold interrupt.
// Assumes a serial-bus front end delivers decoded byte reads and writes, and
// an analog front end delivers raw sample bytes when asked.
`timescale 1ns/10ps
`default_nettype none
`include "light_prox_regs.svh"

// Function
// - The lower threshold is 16 bits held in bytes at offsets 0x04 (low) and 0x05 (high).
// - The upper threshold is 16 bits held in bytes at offsets 0x06 (low) and 0x07 (high).
// - Both lower threshold bytes reset to zero.
// - Both upper threshold bytes reset to all ones.
// - Each integration lasts exactly 2^n oscillator cycles with n picked by bits 3:2 of command two.
// - The result is at most 2^n - 1 counts and sits in the bytes at offsets 0x02 and 0x03.
// - With the recommended resistor integration takes about 90 ms, 5.61 ms, 351 us or 22 us.
// - In modes whose low two mode bits are 11, scheme 1 subtracts ambient infrared on chip at half the resolution of scheme 0.
// - The interrupt fires only after m consecutive out-of-window results, m of 1, 4, 8 or 16.
// - Once fired the pin stays low and flag bit 2 high until a command one transfer ends.
// - Resolution codes 00, 01, 10, 11 select 16, 12, 8 and 4 bits.
// - The result bytes update at the end of every conversion.
module light_prox_core (
    input  wire logic                    clk,          // System clock, 100 MHz
    input  wire logic                    rst_n,        // Synchronous reset, low
    input  wire light_prox_pkg::reg_req_t bus_req,     // Decoded register access
    output logic [7:0]                   rd_data,      // Read data
    input  wire logic [15:0]             sample_raw,   // Raw front-end count
    input  wire logic signed [15:0]      ambient_raw,  // Ambient infrared count
    output logic                         int_n,        // Interrupt pin, low when fired
    output logic                         conv_done     // Conversion end pulse
);
    import light_prox_pkg::*;

    localparam int unsigned OSC_DIV = `SYS_RATE_KHZ / `OSC_RATE_KHZ;

    logic [7:0]  cmd1_q;
    logic [7:0]  cmd2_q;
    logic [7:0]  low_lo_q;
    logic [7:0]  low_hi_q;
    logic [7:0]  high_lo_q;
    logic [7:0]  high_hi_q;
    logic [15:0] result_q;
    logic [4:0]  persist_q;
    logic        flag_q;
    logic [7:0]  div_q;
    logic        osc_tick;
    logic        tmr_done;
    logic [15:0] scaled;
    logic [15:0] low_thr;
    logic [15:0] high_thr;
    logic        out_win;
    logic        fire;
    logic [2:0]  mode_q;
    conv_cfg_t   cfg;

    function automatic logic [4:0] persist_need(input logic [1:0] code);
        case (code)
            2'h0:    persist_need = `PERSIST_CNT_1;
            2'h1:    persist_need = `PERSIST_CNT_4;
            2'h2:    persist_need = `PERSIST_CNT_8;
            default: persist_need = `PERSIST_CNT_16;
        endcase
    endfunction : persist_need

    function automatic logic [16:0] full_scale(input logic [1:0] sel);
        case (sel)
            2'h0:    full_scale = `RES_CYC_16;
            2'h1:    full_scale = `RES_CYC_12;
            2'h2:    full_scale = `RES_CYC_8;
            default: full_scale = `RES_CYC_4;
        endcase
    endfunction : full_scale

    always_ff @(posedge clk) begin
        if (!rst_n || div_q == 8'(OSC_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign osc_tick = (div_q == 8'(OSC_DIV - 1));

    // One driver for the whole configuration word
    assign cfg = '{
        res_sel: cmd2_q[`CMD2_RES_HI:`CMD2_RES_LO],
        scheme:  cmd2_q[`CMD2_SCHEME_BIT],
        run:     (cmd1_q[`CMD1_MODE_HI:`CMD1_MODE_LO] != 3'h0)
    };

    conv_timer u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .osc_tick (osc_tick),
        .cfg      (cfg),
        .done     (tmr_done)
    );

    // Command registers; flag lives apart so hardware can set it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd1_q <= `CMD_RESET;
            cmd2_q <= `CMD_RESET;
        end else if (bus_req.wr) begin
            if (bus_req.addr == `CMD1_ADDR) begin
                cmd1_q <= bus_req.wdata;
            end
            if (bus_req.addr == `CMD2_ADDR) begin
                cmd2_q <= bus_req.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_lo_q  <= `LOW_THR_RESET;
            low_hi_q  <= `LOW_THR_RESET;
            high_lo_q <= `HIGH_THR_RESET;
            high_hi_q <= `HIGH_THR_RESET;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `LOW_THR_LO_ADDR:  low_lo_q  <= bus_req.wdata;
                `LOW_THR_HI_ADDR:  low_hi_q  <= bus_req.wdata;
                `HIGH_THR_LO_ADDR: high_lo_q <= bus_req.wdata;
                `HIGH_THR_HI_ADDR: high_hi_q <= bus_req.wdata;
                default: begin
                end
            endcase
        end
    end

    assign low_thr  = {low_hi_q, low_lo_q};
    assign high_thr = {high_hi_q, high_lo_q};

    // scale raw sample to the selected width
    always_comb begin
        logic [16:0] fs;
        logic signed [16:0] diff;
        fs     = full_scale(cfg.res_sel);
        diff   = 17'($signed({1'b0, sample_raw}) - 17'(ambient_raw));
        scaled = sample_raw;
        if (cfg.scheme && mode_q[1:0] == 2'h3) begin
            // Half resolution, two's complement
            scaled = 16'(diff >>> 1) & 16'(fs - 17'h00001);
        end else if ({1'b0, sample_raw} > fs - 17'h00001) begin
            scaled = 16'(fs - 17'h00001);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_q <= 16'h0000;
        end else if (tmr_done) begin
            result_q <= scaled;
        end
    end

    assign out_win = (scaled < low_thr) || (scaled > high_thr);
    assign fire    = tmr_done && out_win && (persist_q + 5'h01 >= persist_need(cmd1_q[1:0]));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= 3'h0;
        end else begin
            mode_q <= cmd1_q[`CMD1_MODE_HI:`CMD1_MODE_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || mode_q != cmd1_q[`CMD1_MODE_HI:`CMD1_MODE_LO]) begin
            persist_q <= 5'h00;
        end else if (tmr_done) begin
            if (!out_win) begin
                persist_q <= 5'h00;
            end else if (persist_q < `PERSIST_CNT_16) begin
                persist_q <= persist_q + 5'h01;
            end
        end
    end

    // sticky flag, set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (fire) begin
            flag_q <= 1'b1;
        end else if (bus_req.done && bus_req.addr == `CMD1_ADDR) begin
            flag_q <= 1'b0;
        end
    end

    assign int_n     = !flag_q;
    assign conv_done = tmr_done;

    // Read data is registered; the host takes it two edges after presenting the offset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            case (bus_req.addr)
                `CMD1_ADDR:        rd_data <= {cmd1_q[7:3], flag_q, cmd1_q[1:0]};
                `CMD2_ADDR:        rd_data <= cmd2_q;
                `RESULT_LO_ADDR:   rd_data <= result_q[7:0];
                `RESULT_HI_ADDR:   rd_data <= result_q[15:8];
                `LOW_THR_LO_ADDR:  rd_data <= low_lo_q;
                `LOW_THR_HI_ADDR:  rd_data <= low_hi_q;
                `HIGH_THR_LO_ADDR: rd_data <= high_lo_q;
                `HIGH_THR_HI_ADDR: rd_data <= high_hi_q;
                default:           rd_data <= 8'h00;
            endcase
        end
    end

    low_reset_a: assert property (@(posedge clk) !rst_n |=> low_thr == 16'h0000)
        else $error("lower threshold not zero after reset");
    high_reset_a: assert property (@(posedge clk) !rst_n |=> high_thr == 16'hffff)
        else $error("upper threshold not ones after reset");
    low_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == `LOW_THR_LO_ADDR |=> low_lo_q == $past(bus_req.wdata))
        else $error("lower threshold byte write lost");
    high_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == `HIGH_THR_HI_ADDR |=> high_hi_q == $past(bus_req.wdata))
        else $error("upper threshold byte write lost");
    result_update_a: assert property (@(posedge clk) disable iff (!rst_n)
        tmr_done |=> result_q == $past(scaled))
        else $error("result not updated at conversion end");
    result_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        tmr_done |=> {1'b0, result_q} < full_scale($past(cfg.res_sel)))
        else $error("result beyond full scale");
    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        flag_q && !(bus_req.done && bus_req.addr == `CMD1_ADDR) |=> flag_q && !int_n == flag_q)
        else $error("interrupt flag dropped without clear");
    persist_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        tmr_done && !out_win |=> persist_q == 5'h00)
        else $error("persist count survived in-window result");
    persist_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !flag_q && !(tmr_done && out_win) |=> !flag_q)
        else $error("interrupt raised without persist run");
    low_hi_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == `LOW_THR_HI_ADDR |=> low_hi_q == $past(bus_req.wdata))
        else $error("lower threshold high byte write lost");
    high_lo_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == `HIGH_THR_LO_ADDR |=> high_lo_q == $past(bus_req.wdata))
        else $error("upper threshold low byte write lost");
    low_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.addr == `LOW_THR_LO_ADDR |=> rd_data == $past(low_lo_q))
        else $error("lower threshold byte read wrong");
    high_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.addr == `HIGH_THR_HI_ADDR |=> rd_data == $past(high_hi_q))
        else $error("upper threshold byte read wrong");
    result_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.wr && !tmr_done && (bus_req.addr == `RESULT_LO_ADDR || bus_req.addr == `RESULT_HI_ADDR)
        |=> result_q == $past(result_q))
        else $error("result bytes changed by a write");
    scaled_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        {1'b0, scaled} < full_scale(cfg.res_sel))
        else $error("scaled sample beyond full scale");
    flag_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.addr == `CMD1_ADDR |=> rd_data[`CMD1_FLAG_BIT] == $past(flag_q))
        else $error("readback flag differs from interrupt flag");
    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.done && bus_req.addr == `CMD1_ADDR && !fire |=> !flag_q && int_n)
        else $error("interrupt not cleared by command transfer");
    fire_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        fire |=> flag_q && !int_n)
        else $error("interrupt not raised after persist run");
    persist_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
        persist_q <= `PERSIST_CNT_16)
        else $error("persist count beyond sixteen");
    mode_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_q != cmd1_q[`CMD1_MODE_HI:`CMD1_MODE_LO] |=> persist_q == 5'h00)
        else $error("persist count survived mode change");
endmodule : light_prox_core
`default_nettype wire

// ### test/host_model.sv
// Host controller model: issues decoded byte transfers to the core.
// Assumes the core registers read data one edge after the offset is presented.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic                    clk,     // System clock
    output var light_prox_pkg::reg_req_t bus_req, // Register access
    input  wire logic [7:0]              rd_data  // Read data
);
    import light_prox_pkg::*;
    initial bus_req = '0;
    // Released lines show the inverse of the last value
    task automatic idle();
        bus_req.addr  <= ~bus_req.addr;
        bus_req.wdata <= ~bus_req.wdata;
    endtask : idle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req.wr    <= 1'b1;
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        @(posedge clk);
        bus_req.wr    <= 1'b0;
        bus_req.done  <= 1'b1;
        @(posedge clk);
        bus_req.done  <= 1'b0;
        idle();
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req.rd    <= 1'b1;
        bus_req.addr  <= a;
        @(posedge clk);
        bus_req.done  <= 1'b1;
        @(posedge clk);
        d = rd_data;
        bus_req.rd    <= 1'b0;
        bus_req.done  <= 1'b0;
        idle();
    endtask : rd_reg
    function automatic int prox_less_ir(input logic [15:0] prox, input logic [15:0] ir);
        return int'(prox) - int'(ir);
    endfunction : prox_less_ir
endmodule : host_model
`default_nettype wire

// ### test/test_light_prox_core.sv
// Self-checking bench for the light/proximity core with a reference model.
// Assumes the host model and the core sources are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_light_prox_core;
    import light_prox_pkg::*;
    localparam int OSC_DIV = 137;
    logic               clk;
    logic               rst_n;
    reg_req_t           bus_req;
    logic [7:0]         rd_data;
    logic [15:0]        sample_raw;
    logic signed [15:0] ambient_raw;
    logic               int_n;
    logic               conv_done;
    logic [7:0]         rb;
    logic [15:0]        res;
    logic [15:0]        res_ir;
    logic [31:0]        thr;
    int                 seed = 71267;
    int                 bad_count = 0;
    int                 checked = 0;
    int                 lo_m, hi_m, m_m, cnt_m, scheme_m, flag_m, exp_m, gap, cyc, last_cyc, dif, mode_m;
    int                 plen [4] = '{1, 4, 8, 16};
    logic [7:0]         rst_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};

    light_prox_core uut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
        .sample_raw(sample_raw), .ambient_raw(ambient_raw), .int_n(int_n), .conv_done(conv_done));
    host_model host (.clk(clk), .bus_req(bus_req), .rd_data(rd_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (rst_n === 1'b1 && conv_done === 1'b1) begin
            gap = cyc - last_cyc;
            last_cyc = cyc;
            if (scheme_m)
                exp_m = ((int'(sample_raw) - int'(ambient_raw)) >>> 1) & 15;
            else
                exp_m = (sample_raw > 16'h000f) ? 15 : int'(sample_raw);
            if (exp_m < lo_m || exp_m > hi_m) begin
                cnt_m = cnt_m + 1;
                if (cnt_m >= m_m)
                    flag_m = 1;
            end else begin
                cnt_m = 0;
            end
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic set_thr(input int lo, input int hi);
        host.wr_reg(8'h04, lo[7:0]);
        host.wr_reg(8'h05, lo[15:8]);
        host.wr_reg(8'h06, hi[7:0]);
        host.wr_reg(8'h07, hi[15:8]);
        lo_m = lo;
        hi_m = hi;
    endtask : set_thr

    task automatic wr_cmd1(input logic [7:0] v);
        host.wr_reg(8'h00, v);
        flag_m = 0;
        // Run count restarts only when the operating mode changes
        if (int'(v[7:5]) != mode_m)
            cnt_m = 0;
        mode_m = int'(v[7:5]);
        m_m = plen[v[1:0]];
    endtask : wr_cmd1

    function automatic logic [15:0] in_val();
        return 16'(lo_m + int'({$random(seed)} % (hi_m - lo_m + 1)));
    endfunction : in_val

    function automatic logic [15:0] out_val();
        return ($random(seed) & 1) ? (16'h0010 | 16'($random(seed))) : 16'({$random(seed)} % lo_m);
    endfunction : out_val

    task automatic conv(input logic [15:0] v, output logic [15:0] r);
        int         n;
        logic [7:0] b0;
        logic [7:0] b1;
        n = 0;
        @(posedge clk);
        sample_raw  <= v;
        ambient_raw <= 16'($random(seed));
        do begin
            @(posedge clk);
            n++;
        end while (conv_done !== 1'b1 && n < 3000);
        if (n >= 3000)
            chk("conv_done", 16'h0001, 16'h0000);
        host.rd_reg(8'h02, b0);
        host.rd_reg(8'h03, b1);
        r = {b1, b0};
        chk("result", 16'(exp_m), r);
        chk("int_n", {15'h0, !flag_m}, {15'h0, int_n});
    endtask : conv

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    initial begin
        // 44 conversions of 2192 cycles plus setup
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("[FAIL] run_time expected finish seen timeout");
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        sample_raw = 16'h0000;
        ambient_raw = 16'h0000;
        lo_m = 0;
        hi_m = 65535;
        m_m = 1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            host.rd_reg(8'(a), rb);
            chk("reset_value", {8'h00, (a < 8) ? rst_exp[a] : 8'h00}, {8'h00, rb});
        end
        for (int a = 2; a < 4; a++) begin
            host.wr_reg(8'(a), 8'h5a);
            host.rd_reg(8'(a), rb);
            chk("result_ro", 16'h0000, {8'h00, rb});
        end
        thr = $random(seed);
        set_thr(thr[15:0], thr[31:16]);
        for (int a = 4; a < 8; a++) begin
            host.rd_reg(8'(a), rb);
            chk("threshold", {8'h00, thr[(a - 4) * 8 +: 8]}, {8'h00, rb});
        end
        host.wr_reg(8'h01, 8'h0c);
        set_thr(3 + {$random(seed)} % 4, 9 + {$random(seed)} % 4);
        wr_cmd1(8'ha0);
        repeat (2) conv(in_val(), res);
        chk("period", 16'(16 * OSC_DIV), 16'(gap));
        for (int c = 0; c < 4; c++) begin
            wr_cmd1(8'ha0 | 8'(c));
            conv(in_val(), res);
            if (c == 1) begin
                conv(16'(hi_m + 1), res);
                conv(16'(lo_m - 1), res);
                conv(out_val(), res);
                conv(16'(lo_m), res);
            end
            repeat (plen[c]) conv(out_val(), res);
            if (c == 0)
                conv(16'(hi_m), res);
            host.rd_reg(8'h00, rb);
            chk("cmd1", 16'(8'ha4 | 8'(c)), {8'h00, rb});
            flag_m = 0;
            repeat (2) @(posedge clk);
            chk("int_n_clear", 16'h0001, {15'h0, int_n});
        end
        set_thr(0, 15);
        host.wr_reg(8'h01, 8'h8c);
        scheme_m = 1;
        wr_cmd1(8'he0);
        repeat (2) conv(16'($random(seed)), res);
        host.wr_reg(8'h01, 8'h0c);
        scheme_m = 0;
        conv(16'($random(seed)) & 16'h001f, res);
        dif = exp_m;
        wr_cmd1(8'hc0);
        conv(16'($random(seed)) & 16'h001f, res_ir);
        chk("prox_less_ir", 16'(dif - exp_m), 16'(host.prox_less_ir(res, res_ir)));
        end_of_test();
    end
endmodule : test_light_prox_core
`default_nettype wire
